// file: rtl/iep_irq_ctrl.sv
// Interrupt enable, priority and pin trigger controller with APB registers
`timescale 1ns/1ps
module iep_irq_ctrl #(
    parameter int P1_W = 8
) (
    input  wire logic            mclk,
    input  wire logic            reset,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Pins
    input  wire logic            ext_pin_a,
    input  wire logic            ext_pin_b,
    input  wire logic            ext_pin_c,
    input  wire logic [P1_W-1:0] port_one,
    // Peripheral requests
    input  wire logic            timer0_req,
    input  wire logic            timer1_req,
    input  wire logic            serial_req,
    input  wire logic            timer2_req,
    input  wire logic            timer3_req,
    input  wire logic            adc_req,
    input  wire logic            twi_req,
    input  wire logic            pulse_gen_detect_req,
    input  wire logic            comparator_req,
    input  wire logic            pulse_width_req,
    // CPU core side
    output logic                 cpu_irq_req,
    output logic      [3:0]      cpu_irq_id,
    output logic      [1:0]      cpu_irq_level,
    input  wire logic            cpu_irq_ack,
    input  wire logic            cpu_irq_return,
    output logic                 stop_wake,
    output logic                 irq
);
    localparam int N = iep_pkg::NUM_SRC;

    logic [7:0]            legacy_en_q;
    logic [7:0]            peripheral_irq_enable_q;
    logic [7:0]            legacy_priority_low_q;
    logic [7:0]            legacy_priority_high_q;
    logic [7:0]            extended_priority_low_q;
    logic [7:0]            extended_priority_high_q;
    logic                  ext_pin_a_trigger_sel_q;
    logic                  ext_pin_b_trigger_sel_q;
    logic [4:0]            evt_status_q;
    logic [4:0]            evt_status_d;
    logic [4:0]            evt_mask_q;
    logic [3:0]            active_q;
    logic [3:0]            active_d;
    logic                  wake_q;
    logic                  cpu_req_q;
    logic [3:0]            cpu_id_q;
    logic [1:0]            cpu_lvl_q;

    logic [7:0]            reg_idx;
    logic                  addr_ok;
    logic                  wr_en;
    logic                  rd_en;
    logic                  hit_trig;
    logic                  hit_aux;
    logic                  hit_leg_en;
    logic                  hit_per_en;
    logic                  hit_lp_lo;
    logic                  hit_lp_hi;
    logic                  hit_ep_lo;
    logic                  hit_ep_hi;
    logic                  hit_status;
    logic                  hit_mask;
    logic                  hit_state;
    logic [7:0]            rd_byte;

    logic [3:0]            flag_q;
    logic [3:0]            flag_set;
    logic [3:0]            flag_clr;
    logic [3:0]            ack_clr;
    logic [3:0]            sw_clr;
    logic                  req_a;
    logic                  req_b;
    logic [N-1:0]          src_req;
    logic [N-1:0]          src_en;
    logic [N-1:0]          gated_req;
    logic [N-1:0]          prio_hi;
    logic [N-1:0]          prio_lo;
    logic                  win_valid;
    logic [3:0]            win_id;
    logic [1:0]            win_level;
    logic                  wake_now;
    logic                  gate;
    logic [4:0]            evt_in;

    // APB decode; zero-wait slave, unmapped index answers with an error
    assign reg_idx    = paddr[9:2];
    assign hit_trig   = reg_idx == iep_pkg::IDX_TRIG_CTRL;
    assign hit_aux    = reg_idx == iep_pkg::IDX_AUX_FLAGS;
    assign hit_leg_en = reg_idx == iep_pkg::IDX_LEGACY_EN;
    assign hit_per_en = reg_idx == iep_pkg::IDX_PERIPH_EN;
    assign hit_lp_lo  = reg_idx == iep_pkg::IDX_LEG_PRIO_LO;
    assign hit_lp_hi  = reg_idx == iep_pkg::IDX_LEG_PRIO_HI;
    assign hit_ep_lo  = reg_idx == iep_pkg::IDX_EXT_PRIO_LO;
    assign hit_ep_hi  = reg_idx == iep_pkg::IDX_EXT_PRIO_HI;
    assign hit_status = reg_idx == iep_pkg::IDX_EVT_STATUS;
    assign hit_mask   = reg_idx == iep_pkg::IDX_EVT_MASK;
    assign hit_state  = reg_idx == iep_pkg::IDX_CORE_STATE;
    assign addr_ok    = (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0) &
                        (hit_trig | hit_aux | hit_leg_en | hit_per_en | hit_lp_lo | hit_lp_hi |
                         hit_ep_lo | hit_ep_hi | hit_status | hit_mask | hit_state);
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~addr_ok;
    assign wr_en      = psel & penable & pwrite & addr_ok;
    assign rd_en      = psel & ~penable & ~pwrite & addr_ok;

    // Read view; unused bits read zero
    assign rd_byte =
        hit_trig   ? {4'h0, flag_q[1], ext_pin_b_trigger_sel_q, flag_q[0], ext_pin_a_trigger_sel_q} :
        hit_aux    ? {5'h00, flag_q[2], flag_q[3], 1'b0} :
        hit_leg_en ? {legacy_en_q[7], 1'b0, legacy_en_q[5:0]} :
        hit_per_en ? peripheral_irq_enable_q :
        hit_lp_lo  ? {2'h0, legacy_priority_low_q[5:0]} :
        hit_lp_hi  ? {2'h0, legacy_priority_high_q[5:0]} :
        hit_ep_lo  ? extended_priority_low_q :
        hit_ep_hi  ? extended_priority_high_q :
        hit_status ? {3'h0, evt_status_q} :
        hit_mask   ? {3'h0, evt_mask_q} :
        hit_state  ? {1'b0, wake_q, cpu_lvl_q, active_q} : 8'h00;

    // Read data is captured in the setup cycle so it stands through the access phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Enable and priority registers, all cleared by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            legacy_en_q              <= iep_pkg::RST_ENABLE;
            peripheral_irq_enable_q  <= iep_pkg::RST_ENABLE;
            legacy_priority_low_q    <= iep_pkg::RST_PRIO;
            legacy_priority_high_q   <= iep_pkg::RST_PRIO;
            extended_priority_low_q  <= iep_pkg::RST_PRIO;
            extended_priority_high_q <= iep_pkg::RST_PRIO;
        end else if (wr_en) begin
            if (hit_leg_en) begin
                legacy_en_q <= {pwdata[7], 1'b0, pwdata[5:0]};
            end
            if (hit_per_en) begin
                peripheral_irq_enable_q <= pwdata[7:0];
            end
            if (hit_lp_lo) begin
                legacy_priority_low_q <= {2'h0, pwdata[5:0]};
            end
            if (hit_lp_hi) begin
                legacy_priority_high_q <= {2'h0, pwdata[5:0]};
            end
            if (hit_ep_lo) begin
                extended_priority_low_q <= pwdata[7:0];
            end
            if (hit_ep_hi) begin
                extended_priority_high_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ext_pin_a_trigger_sel_q <= iep_pkg::RST_TRIG[iep_pkg::TRIG_SEL_A_BIT];
            ext_pin_b_trigger_sel_q <= iep_pkg::RST_TRIG[iep_pkg::TRIG_SEL_B_BIT];
        end else if (wr_en & hit_trig) begin
            ext_pin_a_trigger_sel_q <= pwdata[iep_pkg::TRIG_SEL_A_BIT];
            ext_pin_b_trigger_sel_q <= pwdata[iep_pkg::TRIG_SEL_B_BIT];
        end
    end

    // Flag clears: service entry, or software writing zero to a flag bit
    assign ack_clr[0] = cpu_irq_ack & (cpu_id_q == iep_pkg::SRC_EXT_A);
    assign ack_clr[1] = cpu_irq_ack & (cpu_id_q == iep_pkg::SRC_EXT_B);
    assign ack_clr[2] = cpu_irq_ack & (cpu_id_q == iep_pkg::SRC_EXT_C);
    assign ack_clr[3] = cpu_irq_ack & (cpu_id_q == iep_pkg::SRC_PORT_ONE);
    assign sw_clr[0]  = wr_en & hit_trig & ~pwdata[iep_pkg::FLAG_A_BIT];
    assign sw_clr[1]  = wr_en & hit_trig & ~pwdata[iep_pkg::FLAG_B_BIT];
    assign sw_clr[2]  = wr_en & hit_aux & ~pwdata[iep_pkg::AUX_C_BIT];
    assign sw_clr[3]  = wr_en & hit_aux & ~pwdata[iep_pkg::AUX_P1_BIT];
    assign flag_clr   = ack_clr | sw_clr;

    // Pin a, b, c and port-one change sources
    iep_pin_trigger #(
        .P1_W (P1_W)
    ) u_pins (
        .mclk                  (mclk),
        .reset                 (reset),
        .ext_pin_a             (ext_pin_a),
        .ext_pin_b             (ext_pin_b),
        .ext_pin_c             (ext_pin_c),
        .port_one              (port_one),
        .ext_pin_a_trigger_sel (ext_pin_a_trigger_sel_q),
        .ext_pin_b_trigger_sel (ext_pin_b_trigger_sel_q),
        .flag_clr              (flag_clr),
        .flag_q                (flag_q),
        .flag_set              (flag_set),
        .req_a                 (req_a),
        .req_b                 (req_b)
    );

    // Source vector: legacy ids 0..5, extended ids 6..13 in register bit order
    assign src_req = {pulse_width_req, comparator_req, pulse_gen_detect_req, twi_req, adc_req,
                      flag_q[2], flag_q[3], timer3_req,
                      timer2_req, serial_req, timer1_req, req_b, timer0_req, req_a};
    assign gate      = legacy_en_q[iep_pkg::GATE_BIT];
    assign src_en    = {peripheral_irq_enable_q, legacy_en_q[iep_pkg::LEGACY_W-1:0]};
    assign gated_req = src_req & src_en & {N{gate}};
    assign prio_hi   = {extended_priority_high_q, legacy_priority_high_q[iep_pkg::LEGACY_W-1:0]};
    assign prio_lo   = {extended_priority_low_q, legacy_priority_low_q[iep_pkg::LEGACY_W-1:0]};

    iep_prio_arbiter #(
        .N (N)
    ) u_arb (
        .req           (gated_req),
        .prio_hi       (prio_hi),
        .prio_lo       (prio_lo),
        .active_levels (active_q),
        .win_valid     (win_valid),
        .win_id        (win_id),
        .win_level     (win_level)
    );

    // Request to the core is registered; ack enters a level, return leaves the top one
    always_comb begin
        active_d = active_q;
        if (cpu_irq_return) begin
            if (active_q[3]) begin
                active_d[3] = 1'b0;
            end else if (active_q[2]) begin
                active_d[2] = 1'b0;
            end else if (active_q[1]) begin
                active_d[1] = 1'b0;
            end else begin
                active_d[0] = 1'b0;
            end
        end
        if (cpu_irq_ack & cpu_req_q) begin
            active_d[cpu_lvl_q] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            active_q  <= 4'h0;
            cpu_req_q <= 1'b0;
            cpu_id_q  <= 4'h0;
            cpu_lvl_q <= 2'h0;
        end else begin
            active_q  <= active_d;
            cpu_req_q <= win_valid & ~cpu_irq_ack;
            cpu_id_q  <= win_id;
            cpu_lvl_q <= win_level;
        end
    end

    assign cpu_irq_req   = cpu_req_q;
    assign cpu_irq_id    = cpu_id_q;
    assign cpu_irq_level = cpu_lvl_q;

    // Stop wake: any enabled pin source, gate not needed
    assign wake_now = (legacy_en_q[0] & (~ext_pin_a | flag_q[0])) |
                      (legacy_en_q[2] & (~ext_pin_b | flag_q[1])) |
                      (peripheral_irq_enable_q[2] & (~ext_pin_c | flag_q[2])) |
                      (peripheral_irq_enable_q[1] & flag_q[3]);

    always_ff @(posedge mclk) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_now;
        end
    end

    assign stop_wake = wake_q;

    // Sticky event status, write one to clear, set wins
    assign evt_in = {wake_now & ~wake_q, flag_set};

    always_comb begin
        evt_status_d = evt_status_q;
        if (wr_en & hit_status) begin
            evt_status_d = evt_status_q & ~pwdata[iep_pkg::EVT_W-1:0];
        end
        evt_status_d = evt_status_d | evt_in;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            evt_status_q <= iep_pkg::RST_EVT;
            evt_mask_q   <= iep_pkg::RST_EVT;
        end else begin
            evt_status_q <= evt_status_d;
            if (wr_en & hit_mask) begin
                evt_mask_q <= pwdata[iep_pkg::EVT_W-1:0];
            end
        end
    end

    assign irq = |(evt_status_q & evt_mask_q);
endmodule

// file: rtl/iep_pkg.sv
// Package of register indices, field positions, reset values and source ids
package iep_pkg;
    // Register indices; byte address on APB is four times the index
    localparam logic [7:0] IDX_TRIG_CTRL     = 8'h88;
    localparam logic [7:0] IDX_AUX_FLAGS     = 8'h95;
    localparam logic [7:0] IDX_LEGACY_EN     = 8'ha8;
    localparam logic [7:0] IDX_PERIPH_EN     = 8'ha9;
    localparam logic [7:0] IDX_LEG_PRIO_LO   = 8'hb8;
    localparam logic [7:0] IDX_LEG_PRIO_HI   = 8'hb9;
    localparam logic [7:0] IDX_EXT_PRIO_LO   = 8'hba;
    localparam logic [7:0] IDX_EXT_PRIO_HI   = 8'hbb;
    localparam logic [7:0] IDX_EVT_STATUS    = 8'hc0;
    localparam logic [7:0] IDX_EVT_MASK      = 8'hc1;
    localparam logic [7:0] IDX_CORE_STATE    = 8'hc2;

    // Reset values
    localparam logic [7:0] RST_ENABLE        = 8'h00;
    localparam logic [7:0] RST_PRIO          = 8'h00;
    localparam logic [7:0] RST_TRIG          = 8'h00;
    localparam logic [4:0] RST_EVT           = 5'h00;

    // Legacy enable register fields
    localparam int GATE_BIT                  = 7;
    localparam int LEGACY_W                  = 6;
    // Trigger control register fields
    localparam int TRIG_SEL_A_BIT            = 0;
    localparam int FLAG_A_BIT                = 1;
    localparam int TRIG_SEL_B_BIT            = 2;
    localparam int FLAG_B_BIT                = 3;
    // Auxiliary flag register fields
    localparam int AUX_P1_BIT                = 1;
    localparam int AUX_C_BIT                 = 2;
    // Event status fields
    localparam int EVT_A                     = 0;
    localparam int EVT_B                     = 1;
    localparam int EVT_C                     = 2;
    localparam int EVT_P1                    = 3;
    localparam int EVT_WAKE                  = 4;
    localparam int EVT_W                     = 5;

    // Source ids; a lower id wins a tie at equal level
    localparam int NUM_SRC                   = 14;
    localparam logic [3:0] SRC_EXT_A         = 4'h0;
    localparam logic [3:0] SRC_EXT_B         = 4'h2;
    localparam logic [3:0] SRC_PORT_ONE      = 4'h7;
    localparam logic [3:0] SRC_EXT_C         = 4'h8;
    localparam int LEVELS                    = 4;
endpackage

// file: rtl/iep_pin_trigger.sv
// Pin edge, level and port-one change detection with sticky edge flags
`timescale 1ns/1ps
module iep_pin_trigger #(
    parameter int P1_W = 8
) (
    input  wire logic            mclk,
    input  wire logic            reset,
    input  wire logic            ext_pin_a,
    input  wire logic            ext_pin_b,
    input  wire logic            ext_pin_c,
    input  wire logic [P1_W-1:0] port_one,
    input  wire logic            ext_pin_a_trigger_sel,
    input  wire logic            ext_pin_b_trigger_sel,
    input  wire logic [3:0]      flag_clr,
    output logic      [3:0]      flag_q,
    output logic      [3:0]      flag_set,
    output logic                 req_a,
    output logic                 req_b
);
    logic [2:0]      pin_prev_q;
    logic [P1_W-1:0] p1_prev_q;
    logic            primed_q;
    logic [2:0]      pin_now;

    assign pin_now     = {ext_pin_c, ext_pin_b, ext_pin_a};
    // Falling edge on each pin, any change on port one
    assign flag_set[0] = primed_q & pin_prev_q[0] & ~pin_now[0];
    assign flag_set[1] = primed_q & pin_prev_q[1] & ~pin_now[1];
    assign flag_set[2] = primed_q & pin_prev_q[2] & ~pin_now[2];
    assign flag_set[3] = primed_q & (|(p1_prev_q ^ port_one));
    // Select 1 uses the edge flag, 0 the low level
    assign req_a       = ext_pin_a_trigger_sel ? flag_q[0] : ~ext_pin_a;
    assign req_b       = ext_pin_b_trigger_sel ? flag_q[1] : ~ext_pin_b;

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_prev_q <= 3'h7;
            p1_prev_q  <= '0;
            primed_q   <= 1'b0;
        end else begin
            pin_prev_q <= pin_now;
            p1_prev_q  <= port_one;
            primed_q   <= 1'b1;
        end
    end

    // Set wins over clear; flags set whatever the enables say
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_flag
            always_ff @(posedge mclk) begin
                if (reset) begin
                    flag_q[i] <= 1'b0;
                end else if (flag_set[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (flag_clr[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// file: rtl/iep_prio_arbiter.sv
// Four-level priority selection with fixed tie order and preemption check
`timescale 1ns/1ps
module iep_prio_arbiter #(
    parameter int N = 14
) (
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] prio_hi,
    input  wire logic [N-1:0] prio_lo,
    input  wire logic [3:0]   active_levels,
    output logic              win_valid,
    output logic [3:0]        win_id,
    output logic [1:0]        win_level
);
    logic [3:0]   lvl_any;
    logic [N-1:0] lvl_req [4];
    logic [1:0]   top_lvl;
    logic [N-1:0] top_req;
    logic         run_valid;
    logic [1:0]   run_lvl;

    // Level of each source is the high/low bit pair
    genvar l;
    generate
        for (l = 0; l < 4; l++) begin : g_lvl
            localparam logic [1:0] LV = 2'(l);
            assign lvl_req[l] = req & ({N{LV[1]}} ~^ prio_hi) & ({N{LV[0]}} ~^ prio_lo);
            assign lvl_any[l] = |lvl_req[l];
        end
    endgenerate

    assign top_lvl   = lvl_any[3] ? 2'h3 : lvl_any[2] ? 2'h2 : lvl_any[1] ? 2'h1 : 2'h0;
    assign top_req   = lvl_req[top_lvl];
    assign run_valid = |active_levels;
    assign run_lvl   = active_levels[3] ? 2'h3 : active_levels[2] ? 2'h2 :
                       active_levels[1] ? 2'h1 : 2'h0;
    // Higher level is served and preempts only a lower running level
    assign win_valid = (|lvl_any) & (~run_valid | (top_lvl > run_lvl));
    assign win_level = top_lvl;

    // Lowest id wins among equals
    always_comb begin
        win_id = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (top_req[i]) begin
                win_id = 4'(i);
            end
        end
    end
endmodule

// file: tb/iep_irq_ctrl_sva.sv
// Checker for the controller's bus and core-facing ports
`timescale 1ns/1ps
module iep_irq_ctrl_sva (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_irq_req,
    input wire logic        cpu_irq_ack,
    input wire logic        stop_wake,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_acc; psel && penable; endsequence
    sequence s_taken; cpu_irq_req && cpu_irq_ack; endsequence
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_err_phase; pslverr |-> s_acc; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_err_unmap; s_acc ##0 (paddr == 12'h040) |-> pslverr; endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped not refused");
    property p_map_en; s_acc ##0 (paddr == 12'h2a4) |-> !pslverr; endproperty
    a_map_en: assert property (p_map_en) else $error("enable refused");
    property p_map_prio; s_acc ##0 (paddr inside {12'h2e0, 12'h2e4, 12'h2e8, 12'h2ec}) |-> !pslverr; endproperty
    a_map_prio: assert property (p_map_prio) else $error("priority refused");
    property p_map_flag; s_acc ##0 (paddr inside {12'h220, 12'h254}) |-> !pslverr; endproperty
    a_map_flag: assert property (p_map_flag) else $error("flag refused");
    property p_ack_drop; s_taken |=> !cpu_irq_req; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
    property p_start; $fell(reset) |-> !cpu_irq_req && !stop_wake && !irq; endproperty
    a_start: assert property (p_start) else $error("outputs set after reset");
endmodule

bind iep_irq_ctrl iep_irq_ctrl_sva i_iep_irq_ctrl_sva (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_ack(cpu_irq_ack), .stop_wake(stop_wake), .irq(irq));

// file: tb/iep_cpu_model.sv
// Core-side model that takes and returns from interrupt requests
`timescale 1ns/1ps
module iep_cpu_model (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       cpu_irq_req,
    input  wire logic [3:0] cpu_irq_id,
    input  wire logic [1:0] cpu_irq_level,
    input  wire logic       ack_en,
    input  wire logic       ret_en,
    output logic            cpu_irq_ack,
    output logic            cpu_irq_return,
    output logic      [3:0] last_id,
    output logic      [1:0] last_lvl
);
    logic [3:0] depth_q;
    wire logic busy = cpu_irq_ack || cpu_irq_return;
    wire logic take = ack_en && cpu_irq_req && !busy;
    wire logic give = ret_en && depth_q != 4'h0 && !cpu_irq_req && !busy;
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_irq_ack    <= 1'b0;
            cpu_irq_return <= 1'b0;
            depth_q        <= 4'h0;
            last_id        <= 4'h0;
            last_lvl       <= 2'h0;
        end else begin
            cpu_irq_ack    <= take;
            cpu_irq_return <= give;
            depth_q        <= depth_q + {3'h0, cpu_irq_ack} - {3'h0, cpu_irq_return};
            if (take) begin
                last_id  <= cpu_irq_id;
                last_lvl <= cpu_irq_level;
            end
        end
    end
endmodule

// file: tb/test_irq_enable_priority_pins.sv
// Self-checking bench for the interrupt enable, priority and pin trigger block
`timescale 1ns/1ps
module test_irq_enable_priority_pins;
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic pa = 1, pb = 1, pc = 1, ack_en = 0, ret_en = 0, err;
    logic pready, pslverr, ack, ret, req, stop_wake, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [9:0] src = 0;
    logic [7:0] p1 = 0;
    logic [3:0] id, last_id;
    logic [1:0] lvl, last_lvl;
    int failures = 0, n_checks = 0;
    logic [7:0] regs[5] = '{8'ha9, 8'hb8, 8'hb9, 8'hba, 8'hbb};
    int bits[6] = '{7, 6, 5, 4, 3, 0};
    int srcs[6] = '{9, 8, 7, 6, 5, 4};
    int ids[6] = '{13, 12, 11, 10, 9, 6};
    iep_irq_ctrl i_iep_irq_ctrl (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pin_a(pa), .ext_pin_b(pb), .ext_pin_c(pc), .port_one(p1),
        .timer0_req(src[0]), .timer1_req(src[1]), .serial_req(src[2]), .timer2_req(src[3]),
        .timer3_req(src[4]), .adc_req(src[5]), .twi_req(src[6]), .pulse_gen_detect_req(src[7]),
        .comparator_req(src[8]), .pulse_width_req(src[9]), .cpu_irq_req(req), .cpu_irq_id(id),
        .cpu_irq_level(lvl), .cpu_irq_ack(ack), .cpu_irq_return(ret), .stop_wake(stop_wake),
        .irq(irq));
    iep_cpu_model i_iep_cpu_model (.mclk(mclk), .reset(reset), .cpu_irq_req(req),
        .cpu_irq_id(id), .cpu_irq_level(lvl), .ack_en(ack_en), .ret_en(ret_en),
        .cpu_irq_ack(ack), .cpu_irq_return(ret), .last_id(last_id), .last_lvl(last_lvl));
    initial forever #4 mclk = ~mclk;
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
        @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(rd[7:0], exp);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 0;
        foreach (regs[i]) rdc(regs[i], 8'h00);
        foreach (regs[i]) begin
            apb(1, regs[i], 8'hff);
            rdc(regs[i], (i == 1 || i == 2) ? 8'h3f : 8'hff);
            apb(1, regs[i], 8'h00);
        end
        apb(0, 8'h10, 8'h00);
        chk({7'h0, err}, 8'h01);
        apb(1, 8'ha8, 8'h80);
        foreach (bits[i]) begin
            src <= 10'h001 << srcs[i];
            apb(1, 8'ha9, 8'h01 << bits[i]);
            @(negedge mclk);
            chk({3'h0, req, id}, 8'(16 + ids[i]));
            apb(1, 8'ha9, ~(8'h01 << bits[i]));
            @(negedge mclk);
            chk({7'h0, req}, 8'h00);
        end
        src <= 10'h010;
        apb(1, 8'ha9, 8'h01);
        apb(1, 8'ha8, 8'h00);
        @(negedge mclk);
        chk({7'h0, req}, 8'h00);
        ack_en <= 1;
        apb(1, 8'ha8, 8'h80);
        repeat (2) @(negedge mclk);
        chk({2'h0, last_lvl, last_id}, 8'h06);
        src <= 10'h210;
        apb(1, 8'hbb, 8'h80);
        apb(1, 8'hba, 8'h80);
        apb(1, 8'ha9, 8'h81);
        repeat (2) @(negedge mclk);
        chk({2'h0, last_lvl, last_id}, 8'h3d);
        ret_en <= 1;
        src <= 10'h000;
        apb(1, 8'ha9, 8'h00);
        apb(1, 8'h88, 8'h01);
        pa <= 0;
        @(posedge mclk);
        rdc(8'h88, 8'h03);
        apb(1, 8'ha8, 8'h81);
        repeat (2) @(negedge mclk);
        chk({2'h0, last_lvl, last_id}, 8'h00);
        rdc(8'h88, 8'h01);
        @(negedge mclk);
        chk({7'h0, req}, 8'h00);
        pa <= 1;
        ack_en <= 0;
        apb(1, 8'ha8, 8'h84);
        pb <= 0;
        apb(1, 8'h88, 8'h00);
        @(negedge mclk);
        chk({2'h0, stop_wake, req, id}, 8'h32);
        pb <= 1;
        ack_en <= 1;
        apb(1, 8'ha8, 8'h00);
        apb(1, 8'ha9, 8'h04);
        pc <= 0;
        repeat (2) @(negedge mclk);
        chk({6'h0, stop_wake, req}, 8'h02);
        rdc(8'h95, 8'h04);
        apb(1, 8'h95, 8'hfb);
        rdc(8'h95, 8'h00);
        pc <= 1;
        apb(1, 8'hc1, 8'h08);
        apb(1, 8'ha9, 8'h02);
        apb(1, 8'ha8, 8'h80);
        p1 <= 8'h10;
        repeat (4) @(negedge mclk);
        chk({1'b0, irq, last_lvl, last_id}, 8'h47);
        apb(1, 8'hc1, 8'h00);
        @(negedge mclk);
        chk({7'h0, irq}, 8'h00);
        apb(1, 8'hc1, 8'h08);
        apb(1, 8'hc0, 8'h08);
        @(negedge mclk);
        chk({7'h0, irq}, 8'h00);
        p1 <= 8'h00;
        repeat (2) @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        wrap_up();
    end
endmodule
